/* design/spp_clk_div.sv */
// Serial clock rate divider: one tick per half period
module spp_clk_div
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       run_i,
    input  wire logic       dbl_i,
    input  wire logic [1:0] spr_i,
    output logic            tick_o
);
    import spp_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             tc;

    // Count to the selected terminal, restart when stopped
    always_comb
    begin
        tc       = (cnt_reg >= spp_term(dbl_i, spr_i));
        cnt_next = cnt_reg + 7'h01;
        if (!run_i || tc)
            cnt_next = '0;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    assign tick_o = run_i & tc;
endmodule : spp_clk_div

/* design/spp_sync.sv */
// Two-stage synchroniser for the serial pins
module spp_sync
(
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic [spp_pkg::SYNC_N-1:0] async_i,
    output logic      [spp_pkg::SYNC_N-1:0] sync_o
);
    import spp_pkg::*;

    logic [SYNC_N-1:0] meta_reg;
    logic [SYNC_N-1:0] meta_next;
    logic [SYNC_N-1:0] sync_reg;
    logic [SYNC_N-1:0] sync_next;

    // First stage feeds only the second
    always_comb
    begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule : spp_sync

/* design/spp_top.sv */
// Serial peripheral port: controller or target byte exchange
module spp_top
(
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    // Software side
    input  wire logic                       ctrl_wr_i,
    input  wire logic [spp_pkg::BYTE_W-1:0] ctrl_wdata_i,
    input  wire logic                       double_rate_enable_i,
    input  wire logic                       data_wr_i,
    input  wire logic [spp_pkg::BYTE_W-1:0] data_wdata_i,
    input  wire logic                       data_rd_i,
    input  wire logic                       status_rd_i,
    input  wire logic                       irq_ack_i,
    input  wire logic                       sck_dir_i,
    input  wire logic                       mosi_dir_i,
    input  wire logic                       miso_dir_i,
    input  wire logic                       sel_dir_out_i,
    output logic [spp_pkg::BYTE_W-1:0]      data_rdata_o,
    output logic                            flag_o,
    output logic                            wcol_o,
    output logic                            role_o,
    output logic                            irq_o,
    // Serial pins
    input  wire logic                       sck_i,
    output logic                            sck_o,
    output logic                            sck_oe_o,
    input  wire logic                       mosi_i,
    output logic                            mosi_o,
    output logic                            mosi_oe_o,
    input  wire logic                       miso_i,
    output logic                            miso_o,
    output logic                            miso_oe_o,
    input  wire logic                       sel_n_i
);
    import spp_pkg::*;

    logic [BYTE_W-1:0] ctrl_reg, ctrl_next;
    logic              role_reg, role_next;
    spp_state_t        state_reg, state_next;
    logic [3:0]        edge_reg, edge_next;
    logic [BYTE_W-1:0] tx_reg, tx_next;
    logic [BYTE_W-1:0] rx_reg, rx_next;
    logic [BYTE_W-1:0] rxbuf_reg, rxbuf_next;
    logic [2:0]        rcnt_reg, rcnt_next;
    logic [PEND_W-1:0] pend_reg, pend_next;
    logic              sck_lvl_reg, sck_lvl_next;
    logic              prev_reg, prev_next;
    logic              flag_reg, flag_next;
    logic              wcol_reg, wcol_next;
    logic              armed_reg, armed_next;
    logic              irq_reg, irq_next;
    logic [5:0]        pin_reg, pin_next;
    logic [SYNC_N-1:0] sync_w;
    logic              tick;

    //----------------------------------------------------------------
    // Pin synchronisers and rate divider
    //----------------------------------------------------------------
    spp_sync u_sync
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({sel_n_i, sck_i, mosi_i, miso_i}),
        .sync_o    (sync_w)
    );

    spp_clk_div u_div
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (state_reg == ST_SHIFT),
        .dbl_i     (double_rate_enable_i),
        .spr_i     ({ctrl_reg[CB_R1], ctrl_reg[CB_R0]}),
        .tick_o    (tick)
    );

    //----------------------------------------------------------------
    // Decoded conditions
    //----------------------------------------------------------------
    logic en, lsb, clock_idle_level, clock_sample_phase, ie, c_act, t_act, sel_s, sck_s;
    logic fault, t_sel, t_chg, lead, trail, c_tick, samp_edge, setup_edge;
    logic first, pend_in, t_samp, samp_now, samp_bit, rx_done;
    logic busy, wr_ok, wcol_set, start, clr;

    // Configuration fields and roles
    assign en    = ctrl_reg[CB_EN];
    assign lsb   = ctrl_reg[CB_LSB];
    assign clock_idle_level  = ctrl_reg[CB_CLOCK_IDLE_LEVEL];
    assign clock_sample_phase  = ctrl_reg[CB_CLOCK_SAMPLE_PHASE];
    assign ie    = ctrl_reg[CB_IE];
    assign c_act = en & role_reg;
    assign t_act = en & ~role_reg;
    assign sel_s = sync_w[SI_SEL];
    assign sck_s = sync_w[SI_SCK];

    // Another controller pulls select low
    assign fault = c_act & ~sel_dir_out_i & ~sel_s;

    // Target edges from the synchronised clock, controller edges from the divider tick
    assign t_sel  = t_act & ~sel_s;
    assign t_chg  = t_sel & (sck_s != prev_reg);
    assign c_tick = tick & (state_reg == ST_SHIFT);
    assign lead   = (t_chg & (prev_reg == clock_idle_level)) | (c_tick & ~edge_reg[0]);
    assign trail  = (t_chg & (prev_reg != clock_idle_level)) | (c_tick & edge_reg[0]);

    // Sample and setup edges from the phase setting
    assign samp_edge  = clock_sample_phase ? trail : lead;
    assign setup_edge = clock_sample_phase ? lead : trail;
    assign first      = role_reg ? (edge_reg == '0) : (rcnt_reg == '0);

    // Controller samples late to match the input synchroniser
    assign pend_in  = samp_edge & c_act;
    assign t_samp   = samp_edge & t_act;
    assign samp_now = pend_reg[PEND_TOP] | t_samp;
    assign samp_bit = role_reg ? sync_w[SI_MISO] : sync_w[SI_MOSI];
    assign rx_done  = samp_now & (rcnt_reg == BIT_LAST);

    // Write acceptance and collision
    assign busy     = (state_reg == ST_SHIFT) | (|pend_reg) | (t_sel & (rcnt_reg != '0));
    assign wr_ok    = data_wr_i & ~busy;
    assign wcol_set = data_wr_i & busy;
    assign start    = wr_ok & c_act & ~fault;
    assign clr      = armed_reg & (data_wr_i | data_rd_i);

    //----------------------------------------------------------------
    // Control word and role
    //----------------------------------------------------------------
    always_comb
    begin
        ctrl_next = ctrl_reg;
        role_next = role_reg;
        if (ctrl_wr_i)
        begin
            ctrl_next = ctrl_wdata_i;
            role_next = ctrl_wdata_i[CB_ROLE];
        end
        if (fault)
            role_next = 1'b0;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_reg <= CTRL_RST;
            role_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            role_reg <= role_next;
        end
    end

    //----------------------------------------------------------------
    // Shift engine
    //----------------------------------------------------------------
    always_comb
    begin
        state_next   = state_reg;
        edge_next    = edge_reg;
        tx_next      = tx_reg;
        rx_next      = rx_reg;
        rxbuf_next   = rxbuf_reg;
        rcnt_next    = rcnt_reg;
        pend_next    = {pend_reg[PEND_TOP-1:0], pend_in};
        sck_lvl_next = sck_lvl_reg;
        prev_next    = sck_s;
        // Next send bit, first leading edge of phase 1 holds
        if (setup_edge && !(clock_sample_phase && first))
            tx_next = spp_shift(lsb, tx_reg, 1'b0);
        // Receive one bit
        if (samp_now)
        begin
            rx_next   = spp_shift(lsb, rx_reg, samp_bit);
            rcnt_next = rcnt_reg + 3'h1;
        end
        if (rx_done)
            rxbuf_next = rx_next;
        // Controller clock edges
        if (c_tick)
        begin
            sck_lvl_next = ~sck_lvl_reg;
            edge_next    = edge_reg + 4'h1;
            if (edge_reg == EDGE_LAST)
                state_next = ST_IDLE;
        end
        if (state_reg != ST_SHIFT)
            sck_lvl_next = clock_idle_level;
        if (wr_ok)
            tx_next = data_wdata_i;
        if (start)
        begin
            state_next = ST_SHIFT;
            edge_next  = '0;
        end
        // Disable, mode fault or deselect drops the partial byte
        if (!en || fault || (t_act && sel_s))
        begin
            state_next = ST_IDLE;
            rcnt_next  = '0;
            pend_next  = '0;
            rx_next    = BYTE_RST;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg   <= ST_IDLE;
            edge_reg    <= '0;
            tx_reg      <= BYTE_RST;
            rx_reg      <= BYTE_RST;
            rxbuf_reg   <= BYTE_RST;
            rcnt_reg    <= '0;
            pend_reg    <= '0;
            sck_lvl_reg <= 1'b0;
            prev_reg    <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            edge_reg    <= edge_next;
            tx_reg      <= tx_next;
            rx_reg      <= rx_next;
            rxbuf_reg   <= rxbuf_next;
            rcnt_reg    <= rcnt_next;
            pend_reg    <= pend_next;
            sck_lvl_reg <= sck_lvl_next;
            prev_reg    <= prev_next;
        end
    end

    //----------------------------------------------------------------
    // Flags and interrupt, set wins over clear
    //----------------------------------------------------------------
    always_comb
    begin
        flag_next  = flag_reg;
        wcol_next  = wcol_reg;
        armed_next = armed_reg;
        if (clr || irq_ack_i)
            flag_next = 1'b0;
        if (rx_done || fault)
            flag_next = 1'b1;
        if (clr)
            wcol_next = 1'b0;
        if (wcol_set)
            wcol_next = 1'b1;
        if (clr)
            armed_next = 1'b0;
        if (status_rd_i && (flag_reg || wcol_reg))
            armed_next = 1'b1;
        irq_next = flag_next & ie;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            flag_reg  <= 1'b0;
            wcol_reg  <= 1'b0;
            armed_reg <= 1'b0;
            irq_reg   <= 1'b0;
        end
        else
        begin
            flag_reg  <= flag_next;
            wcol_reg  <= wcol_next;
            armed_reg <= armed_next;
            irq_reg   <= irq_next;
        end
    end

    //----------------------------------------------------------------
    // Pin drivers and direction overrides
    //----------------------------------------------------------------
    always_comb
    begin
        pin_next[5] = sck_lvl_reg;
        pin_next[4] = c_act & sck_dir_i;
        pin_next[3] = spp_top(lsb, tx_reg);
        pin_next[2] = c_act & mosi_dir_i;
        pin_next[1] = spp_top(lsb, tx_reg);
        pin_next[0] = t_sel & miso_dir_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pin_reg <= '0;
        else
            pin_reg <= pin_next;
    end

    assign sck_o        = pin_reg[5];
    assign sck_oe_o     = pin_reg[4];
    assign mosi_o       = pin_reg[3];
    assign mosi_oe_o    = pin_reg[2];
    assign miso_o       = pin_reg[1];
    assign miso_oe_o    = pin_reg[0];
    assign data_rdata_o = rxbuf_reg;
    assign flag_o       = flag_reg;
    assign wcol_o       = wcol_reg;
    assign role_o       = role_reg;
    assign irq_o        = irq_reg;

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_start_shift: assert property (
        start |=> (state_reg == ST_SHIFT) && (edge_reg == '0))
        else $error("write did not start a byte");
    chk_stop_done: assert property (
        (c_tick && edge_reg == EDGE_LAST && en && !fault) |=> state_reg == ST_IDLE)
        else $error("clock did not stop after sixteen edges");
    chk_irq_raise: assert property (
        (rx_done && ie && !ctrl_wr_i) |=> flag_o && irq_o)
        else $error("completed byte raised no interrupt");
    chk_rx_keep: assert property (
        !rx_done |=> $stable(data_rdata_o))
        else $error("receive buffer changed without a byte");
    chk_miso_quiet: assert property (
        (t_act && sel_s && !ctrl_wr_i) |=> !miso_oe_o)
        else $error("deselected target drives its output");
    chk_wcol_set: assert property (
        wcol_set |=> wcol_o ##1 (wcol_o || $past(clr)))
        else $error("collision flag not held");
    chk_sel_discard: assert property (
        (t_act && sel_s && !ctrl_wr_i) |=> (rcnt_reg == '0) && (pend_reg == '0))
        else $error("deselect kept a partial byte");
    chk_mode_fault: assert property (
        fault |=> !role_o && flag_o && (state_reg == ST_IDLE))
        else $error("select fault not handled");
    chk_tgt_inputs: assert property (
        (t_act && !ctrl_wr_i) |=> !sck_oe_o && !mosi_oe_o)
        else $error("target drives clock or data out");
endmodule : spp_top

/* dv/spp_far.sv */
// Far-side model: target for a controller port, controller for a target port
module spp_far
(
    input  wire logic clk_i,
    input  wire logic lsb_i,
    input  wire logic sel_n_i,
    input  wire logic sck_i,
    input  wire logic mosi_i,
    input  wire logic miso_i,
    output logic      sck_o,
    output logic      mosi_o,
    output logic      miso_o,
    output logic      sel_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx   = 8'h00;
    logic [7:0] rx   = 8'h00;
    logic [7:0] crx  = 8'h00;
    logic       last = 1'b0;
    logic       cur;
    initial
    begin
        sck_o   = 1'b0;
        mosi_o  = 1'b0;
        sel_n_o = 1'b1;
    end
    //------------------------------------------------------------
    // Target side
    //------------------------------------------------------------
    assign cur = lsb_i ? tx[0] : tx[7];
    // Sample on the rising edge, next bit on the falling edge
    always @(posedge sck_i)
        if (!sel_n_i)
            rx <= lsb_i ? {mosi_i, rx[7:1]} : {rx[6:0], mosi_i};
    always @(negedge sck_i)
        if (!sel_n_i)
            tx <= lsb_i ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
    // Released line shows the inverse of its last value
    always @(posedge clk_i)
        if (!sel_n_i)
            last <= cur;
    assign miso_o = sel_n_i ? ~last : cur;
    //------------------------------------------------------------
    // Controller side
    //------------------------------------------------------------
    // Frame of nb bits, each phase six cycles, clock still outside
    task automatic xfer(input logic [7:0] d, input int nb);
        sel_n_o = 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            mosi_o = lsb_i ? d[i] : d[7-i];
            repeat (6) @(negedge clk_i);
            sck_o = 1'b1;
            crx   = lsb_i ? {miso_i, crx[7:1]} : {crx[6:0], miso_i};
            repeat (6) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (6) @(negedge clk_i);
        sel_n_o = 1'b1;
        mosi_o  = ~mosi_o;
    endtask : xfer
endmodule : spp_far

/* dv/spp_top_tb.sv */
// Self-checking bench of the serial peripheral port
module spp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_i;
    logic       sys_rst_i;
    logic       ctrl_wr, data_wr, data_rd, status_rd, irq_ack, dbl, sel_dir, sw_sel_n, lsb, dir;
    logic [7:0] ctrl_wd, data_wd, rdata;
    logic       flag, wcol, role, irq, sck_d, sck_oe, mosi_d, mosi_oe, miso_d, miso_oe;
    wire        sck, mosi, miso, sel_n, f_sck, f_mosi, f_miso, f_sel_n;
    int         error_cnt = 0;
    int         num_checks = 0;
    int         per [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    int         n;
    int         i;
    // Wire levels from all drivers
    assign sck   = sck_oe ? sck_d : f_sck;
    assign mosi  = mosi_oe ? mosi_d : f_mosi;
    assign miso  = miso_oe ? miso_d : f_miso;
    assign sel_n = sw_sel_n & f_sel_n;
    spp_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ctrl_wr_i(ctrl_wr),
        .ctrl_wdata_i(ctrl_wd), .double_rate_enable_i(dbl), .data_wr_i(data_wr),
        .data_wdata_i(data_wd), .data_rd_i(data_rd), .status_rd_i(status_rd),
        .irq_ack_i(irq_ack), .sck_dir_i(dir), .mosi_dir_i(dir), .miso_dir_i(dir),
        .sel_dir_out_i(sel_dir), .data_rdata_o(rdata), .flag_o(flag), .wcol_o(wcol),
        .role_o(role), .irq_o(irq), .sck_i(sck), .sck_o(sck_d), .sck_oe_o(sck_oe),
        .mosi_i(mosi), .mosi_o(mosi_d), .mosi_oe_o(mosi_oe), .miso_i(miso),
        .miso_o(miso_d), .miso_oe_o(miso_oe), .sel_n_i(sel_n));
    spp_far u_far (.clk_i(clk_i), .lsb_i(lsb), .sel_n_i(sel_n), .sck_i(sck),
        .mosi_i(mosi), .miso_i(miso), .sck_o(f_sck), .mosi_o(f_mosi),
        .miso_o(f_miso), .sel_n_o(f_sel_n));
    //------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("unexpected %0s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(negedge clk_i);
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic wr_ctrl(input logic [7:0] v);
        ctrl_wd = v;
        pulse(ctrl_wr);
    endtask : wr_ctrl
    task automatic wr_data(input logic [7:0] v);
        data_wd = v;
        pulse(data_wr);
    endtask : wr_data
    // Bounded wait for the complete flag
    task automatic wait_flag;
        int k;
        for (k = 0; k < 4000 && flag !== 1'b1; k++)
            cyc(1);
        if (k == 4000)
        begin
            error_cnt++;
            end_sim;
        end
        cyc(2);
    endtask : wait_flag
    //------------------------------------------------------------
    // Clock, watchdog, sequence
    //------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (90000) @(posedge clk_i);
        error_cnt++;
        end_sim;
    end
    initial
    begin
        {ctrl_wr, data_wr, data_rd, status_rd, irq_ack, dbl, lsb} = '0;
        {ctrl_wd, data_wd} = '0;
        sel_dir   = 1'b1;
        dir       = 1'b1;
        sw_sel_n  = 1'b1;
        sys_rst_i = 1'b1;
        cyc(20);
        sys_rst_i = 1'b0;
        // Controller byte with a colliding write
        wr_ctrl(8'hd0);
        cyc(1);
        chk("role", role, 1'b1);
        chk("miso_oe", miso_oe, 1'b0);
        chk("sck_oe", sck_oe, 1'b1);
        u_far.tx = 8'h3c;
        sw_sel_n = 1'b0;
        wr_data(8'ha5);
        cyc(3);
        wr_data(8'h11);
        wait_flag;
        chk("rdata", rdata, 8'h3c);
        chk("far rx", u_far.rx, 8'ha5);
        chk("wcol", wcol, 1'b1);
        chk("irq", irq, 1'b1);
        chk("sck idle", sck_d, 1'b0);
        pulse(status_rd);
        pulse(data_rd);
        cyc(2);
        chk("flags", {flag, wcol, irq}, 3'h0);
        dir = 1'b0;
        cyc(2);
        chk("oe off", {sck_oe, mosi_oe}, 2'h0);
        dir = 1'b1;
        sw_sel_n = 1'b1;
        $display("test controller done");
        // Low bit first at double rate
        dbl = 1'b1;
        lsb = 1'b1;
        wr_ctrl(8'hf0);
        u_far.tx = 8'h6b;
        sw_sel_n = 1'b0;
        wr_data(8'h2d);
        wait_flag;
        chk("rdata", rdata, 8'h6b);
        chk("far rx", u_far.rx, 8'h2d);
        pulse(irq_ack);
        cyc(2);
        chk("flag", flag, 1'b0);
        sw_sel_n = 1'b1;
        lsb = 1'b0;
        $display("test bit order done");
        // Every clock rate, idle high, trailing-edge sample
        for (int r = 0; r < 8; r++)
        begin
            dbl = r[2];
            wr_ctrl(8'h5c | r[1:0]);
            cyc(2);
            chk("sck idle", sck_d, 1'b1);
            wr_data(8'h00);
            for (i = 0; i < 600 && sck_d !== 1'b0; i++)
                cyc(1);
            n = 0;
            for (i = 0; i < 600 && sck_d === 1'b0; i++)
            begin
                cyc(1);
                n++;
            end
            for (i = 0; i < 600 && sck_d === 1'b1; i++)
            begin
                cyc(1);
                n++;
            end
            chk("sck period", 8'(n), 8'(per[r]));
            wait_flag;
            pulse(irq_ack);
        end
        dbl = 1'b0;
        $display("test rates done");
        // Select pulled low while it is an input
        wr_ctrl(8'hd0);
        sel_dir  = 1'b0;
        sw_sel_n = 1'b0;
        cyc(6);
        chk("role", role, 1'b0);
        chk("flag", flag, 1'b1);
        sw_sel_n = 1'b1;
        sel_dir  = 1'b1;
        pulse(irq_ack);
        $display("test select fault done");
        // Target role driven by the far controller
        wr_ctrl(8'hc0);
        wr_data(8'h5a);
        cyc(10);
        chk("wcol", wcol, 1'b0);
        chk("miso_oe", miso_oe, 1'b0);
        chk("flag", flag, 1'b0);
        u_far.xfer(8'hc3, 4);
        chk("flag", flag, 1'b0);
        cyc(3);
        wr_data(8'h5a);
        u_far.xfer(8'hc3, 8);
        chk("flag", flag, 1'b1);
        chk("rdata", rdata, 8'hc3);
        chk("far crx", u_far.crx, 8'h5a);
        wr_data(8'h96);
        u_far.xfer(8'h3e, 8);
        chk("far crx", u_far.crx, 8'h96);
        chk("rdata", rdata, 8'h3e);
        chk("irq", irq, 1'b1);
        $display("test target done");
        end_sim;
    end
endmodule : spp_top_tb

/* inc/spp_pkg.sv */
// Package: constants, types and helpers of the serial peripheral port
//--------------------------------------------------------------------
// Notes on behaviour
// - Full duplex: bits out and in together
// - Controller data write starts clock, shifts eight bits
// - After one byte clock stops, complete flag sets
// - Complete flag with enable raises interrupt request
// - Last received byte held in receive buffer
// - Target deselected: idle, controller-in line released
// - Deselected target accepts writes, shifts nothing
// - Target sets complete flag after whole byte
// - Target accepts new send byte before read
// - Read each byte before next one completes
// - Role forces pin directions as tabled
// - Selectable bit order, low or high first
// - Seven controller clock rates, fastest half clock
// - Write collision flag protects running transfer
// - Completed transfer interrupt wakes idle processor
// - Select rising resets target logic, drops partial
// - Select low as input: drop to target, flag
// - Idle level and sample edge are selectable
// - Normal rates divide by 4, 16, 64, 128
//--------------------------------------------------------------------
package spp_pkg;
    localparam int BYTE_W   = 8;
    localparam int SYNC_N   = 4;
    localparam int DIV_W    = 7;
    localparam int PEND_W   = 3;
    localparam int PEND_TOP = PEND_W - 1;

    // Control word field positions
    localparam int CB_IE   = 7;
    localparam int CB_EN   = 6;
    localparam int CB_LSB  = 5;
    localparam int CB_ROLE = 4;
    localparam int CB_CLOCK_IDLE_LEVEL = 3;
    localparam int CB_CLOCK_SAMPLE_PHASE = 2;
    localparam int CB_R1   = 1;
    localparam int CB_R0   = 0;

    // Reset values
    localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

    // Synchronised pin indices
    localparam int SI_SEL  = 3;
    localparam int SI_SCK  = 2;
    localparam int SI_MOSI = 1;
    localparam int SI_MISO = 0;

    // Counts
    localparam logic [3:0] EDGE_LAST = 4'hf;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // Half-period terminal counts of the rate divider
    localparam logic [DIV_W-1:0] TC_DIV2   = 7'h00;
    localparam logic [DIV_W-1:0] TC_DIV4   = 7'h01;
    localparam logic [DIV_W-1:0] TC_DIV8   = 7'h03;
    localparam logic [DIV_W-1:0] TC_DIV16  = 7'h07;
    localparam logic [DIV_W-1:0] TC_DIV32  = 7'h0f;
    localparam logic [DIV_W-1:0] TC_DIV64  = 7'h1f;
    localparam logic [DIV_W-1:0] TC_DIV128 = 7'h3f;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SHIFT = 2'b10} spp_state_t;

    // Rate select to half-period terminal count
    function automatic logic [DIV_W-1:0] spp_term(input logic dbl, input logic [1:0] spr);
        case ({dbl, spr})
            3'h0:    spp_term = TC_DIV4;
            3'h1:    spp_term = TC_DIV16;
            3'h2:    spp_term = TC_DIV64;
            3'h3:    spp_term = TC_DIV128;
            3'h4:    spp_term = TC_DIV2;
            3'h5:    spp_term = TC_DIV8;
            3'h6:    spp_term = TC_DIV32;
            default: spp_term = TC_DIV64;
        endcase
    endfunction : spp_term

    // Bit on the line for the chosen order
    function automatic logic spp_top(input logic lsb, input logic [BYTE_W-1:0] d);
        spp_top = lsb ? d[0] : d[BYTE_W-1];
    endfunction : spp_top

    // Shift one bit in at the far end
    function automatic logic [BYTE_W-1:0] spp_shift(input logic lsb,
                                                    input logic [BYTE_W-1:0] d,
                                                    input logic b);
        spp_shift = lsb ? {b, d[BYTE_W-1:1]} : {d[BYTE_W-2:0], b};
    endfunction : spp_shift
endpackage : spp_pkg
